// ---- logic/mas_pkg.sv ----
// Shared constants for the memory address sequencer.
`default_nettype none
package mas_pkg;
	localparam int ADDR_W = 18;
	localparam int RELOC_W = 8;
	localparam logic [17:0] ADDR_RST = 18'h0_0000;
	localparam logic [7:0] RELOC_RST = 8'h00;
	localparam logic [31:0] RESP_RST = 32'h0000_0000;
	// Bit positions, numbered MSB first: bit 18 is index 17, bit 35 is index 0.
	localparam int BIT30 = 5;
	localparam int BIT35 = 0;
	// Software-visible register byte offsets.
	localparam logic [11:0] OFF_CTRL = 12'h000;
	localparam logic [11:0] OFF_RELOC = 12'h004;
	localparam logic [11:0] OFF_STEP = 12'h008;
	localparam logic [11:0] OFF_SWITCH = 12'h00C;
	localparam logic [11:0] OFF_ADDR = 12'h010;
	localparam logic [11:0] OFF_STATUS = 12'h014;
	localparam logic [11:0] OFF_CHAN = 12'h018;
	// Step register codes, one per documented timing pulse.
	localparam logic [4:0] ST_CLEAR = 5'h01;
	localparam logic [4:0] ST_LD_BUF = 5'h02;
	localparam logic [4:0] ST_LD_PC = 5'h03;
	localparam logic [4:0] ST_LD_SW = 5'h04;
	localparam logic [4:0] ST_LD_INDEX = 5'h05;
	localparam logic [4:0] ST_LD_WREG = 5'h06;
	localparam logic [4:0] ST_SET_TRAP = 5'h07;
	localparam logic [4:0] ST_LD_CHAN = 5'h08;
	localparam logic [4:0] ST_INC = 5'h09;
	localparam logic [4:0] ST_INC_WREG2 = 5'h0A;
	localparam logic [4:0] ST_CHAN_INC = 5'h0B;
	localparam logic [4:0] ST_MEM_RD = 5'h0C;
	localparam logic [4:0] ST_MEM_WR = 5'h0D;
endpackage
`default_nettype wire

// ---- logic/mas_sequencer.sv ----
// Memory address register, relocation, bus address drive and APB control.
//
// Added by the designer: the APB register port and the register addresses.
`default_nettype none
// Overview of operation
// R1 - An 18-bit address register reaches 262,144 words.
// R2 - Bus address is address register plus relocation offset.
// R3 - Bus bits 21-35 driven active low; 26-35 direct, 21-25 relocated.
// R4 - Bank select bits driven true and complement, both active low.
// R5 - Interleave option puts bit 35 in place of bit 21 for bank select.
// R6 - Every load is preceded by a separate clear; sources buffer, counter, switches. The first load after reset is accepted without one.
// R7 - Short addresses set bit 30 and bits 32-35 directly.
// R8 - Increment adds one; second working register fetch breaks carry 32 to 31.
// R9 - Bits 18-31 all zero selects fast memory, unrelocated.
// R10 - Fast select gated off in bootstrap mode; ungated decode still given.
// R11 - Register compared with console switches into one equal level.
// R12 - Trap forms address 40 by setting bit 30.
// R13 - Channel address sets bit 30, channel into 32-34: 40 plus 2n.
// R14 - Instruction start clears, then loads counter or channel address.
// R15 - Address cycle clears, loads index, clears, loads buffer half on indirection.
// R16 - Fetch loads instruction bits 9-12, later buffer right half.
// R17 - Trap, pop-jump, block-move clear at step 1, set or load at step 3.
// R18 - Stack ops and jump-restore clear and reload at steps 9 and 10.
// R19 - Store cycle clears at step 3, loads bits 9-12 at step 5.
// R20 - Increment from keys, trap step 1 and quotient second register store.
// R21 - Channel load with overflow increment simply sets bit 35.
// R22 - Request placed on bus; proceed only after selected memory answers.
// R23 - Write waits for acknowledge only; read waits for data.
// R24 - Eight-bit relocation added to bits 18-25.
// R25 - Relocation inhibited passes address unchanged with no carries.
// R26 - Each timing pulse is a one-cycle strobe; clear and load in successive cycles.
module mas_sequencer
	import mas_pkg::*;
(
	// Clock and reset.
	input wire logic mclk,
	input wire logic sys_rst,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Processor-side load sources.
	input wire logic [17:0] bufferWordRegister,
	input wire logic [17:0] programCounter,
	input wire logic [3:0] instrIndexField,
	input wire logic [3:0] instrAcField,
	// Memory bus, pins from outside.
	input wire logic memAckIn,
	input wire logic memDataReadyIn,
	// Memory bus drive, active low.
	output logic [14:0] busAddrN,
	output logic [4:0] bankSelTrueN,
	output logic [4:0] bankSelCompN,
	output logic fastSelN,
	output logic memReqRdN,
	output logic memReqWrN,
	// Status levels.
	output logic lowAddress,
	output logic addressMatch
);
	typedef enum logic [1:0] {IDLE, WAIT_WR, WAIT_RD} mas_bus_e;
	typedef struct packed {
		logic [17:0] memoryAddressRegister;
		logic [7:0] relocationOffsetRegister;
		logic [17:0] consoleSwitch;
		logic [2:0] channel;
		logic interleave;
		logic inhibitReloc;
		logic bootstrapMode;
		logic needClear;
		logic memAck1;
		logic memAck2;
		logic memRdy1;
		logic memRdy2;
		logic memDone;
		mas_bus_e busState;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic [14:0] busAddrN;
		logic [4:0] bankSelTrueN;
		logic [4:0] bankSelCompN;
		logic fastSelN;
		logic memReqRdN;
		logic memReqWrN;
		logic lowAddress;
		logic addressMatch;
	} mas_state_s;

	mas_state_s q;
	mas_state_s next_q;

	// Increment with optional break of the carry out of bit 32 into bit 31.
	function automatic logic [17:0] incAddr(input logic [17:0] a, input logic breakCarry);
		logic [3:0] low;
		logic [13:0] high;
		low = a[3:0] + 4'h1;
		high = a[17:4];
		if (!breakCarry && (a[3:0] == 4'hF)) begin
			high = a[17:4] + 14'h0001;
		end
		return {high, low};
	endfunction

	logic [7:0] relocSum;
	logic [17:0] relocAddr;
	logic [4:0] bankBits;
	logic lowDecode;
	logic apbAccess;
	logic [4:0] stepCode;

	always_comb begin
		next_q = q;
		relocSum = q.memoryAddressRegister[17:10]; // R25
		if (!q.inhibitReloc) begin
			relocSum = q.memoryAddressRegister[17:10] + q.relocationOffsetRegister; // R2 R24
		end
		relocAddr = {relocSum, q.memoryAddressRegister[9:0]};
		lowDecode = (q.memoryAddressRegister[17:4] == 14'h0000); // R9
		// Fast memory addresses bypass relocation, so bank bits come from the raw register.
		if (lowDecode) begin
			relocAddr = q.memoryAddressRegister;
		end
		bankBits = relocAddr[14:10];
		if (q.interleave) begin
			bankBits = {relocAddr[BIT35], relocAddr[13:10]}; // R5
		end
		apbAccess = psel && penable && !q.pready;
		stepCode = pwdata[4:0];

		next_q.memAck1 = memAckIn;
		next_q.memAck2 = q.memAck1;
		next_q.memRdy1 = memDataReadyIn;
		next_q.memRdy2 = q.memRdy1;
		next_q.pready = 1'b0;
		next_q.pslverr = 1'b0;

		unique case (q.busState)
			IDLE: begin
			end
			WAIT_WR: begin
				if (q.memAck2) begin // R23
					next_q.busState = IDLE;
					next_q.memDone = 1'b1;
					next_q.memReqWrN = 1'b1;
				end
			end
			WAIT_RD: begin
				if (q.memRdy2) begin // R22 R23
					next_q.busState = IDLE;
					next_q.memDone = 1'b1;
					next_q.memReqRdN = 1'b1;
				end
			end
			default: next_q.busState = IDLE;
		endcase

		if (apbAccess) begin
			next_q.pready = 1'b1;
			next_q.prdata = RESP_RST;
			if (pwrite) begin
				unique case (paddr)
					OFF_CTRL: begin
						next_q.interleave = pwdata[0];
						next_q.inhibitReloc = pwdata[1];
						next_q.bootstrapMode = pwdata[2];
					end
					OFF_RELOC: next_q.relocationOffsetRegister = pwdata[7:0];
					OFF_SWITCH: next_q.consoleSwitch = pwdata[17:0];
					OFF_CHAN: next_q.channel = pwdata[2:0];
					OFF_STEP: begin
						// Each write is one timing pulse, so clear and load land in separate cycles.
						if (stepCode == ST_CLEAR) begin // R26
							next_q.memoryAddressRegister = ADDR_RST; // R6 R14 R15 R17 R18 R19
							next_q.needClear = 1'b0;
						end else if ((stepCode >= ST_LD_BUF) && (stepCode <= ST_CHAN_INC)
							&& (stepCode != ST_INC) && (stepCode != ST_INC_WREG2)
							&& q.needClear) begin
							// A load after an earlier load with no clear in between is refused; the first load after reset is accepted.
							next_q.pslverr = 1'b1; // R6
						end else begin
							unique case (stepCode)
								ST_LD_BUF: next_q.memoryAddressRegister = bufferWordRegister; // R15 R16 R17
								ST_LD_PC: next_q.memoryAddressRegister = programCounter; // R14
								ST_LD_SW: next_q.memoryAddressRegister = q.consoleSwitch; // R6
								ST_LD_INDEX: next_q.memoryAddressRegister[3:0] = instrIndexField; // R7 R15
								ST_LD_WREG: next_q.memoryAddressRegister[3:0] = instrAcField; // R16 R19
								ST_SET_TRAP: next_q.memoryAddressRegister[BIT30] = 1'b1; // R12 R17
								ST_LD_CHAN: begin
									next_q.memoryAddressRegister[BIT30] = 1'b1; // R13 R14
									next_q.memoryAddressRegister[3:1] = q.channel;
								end
								ST_CHAN_INC: begin
									next_q.memoryAddressRegister[BIT30] = 1'b1; // R21
									next_q.memoryAddressRegister[3:1] = q.channel;
									next_q.memoryAddressRegister[BIT35] = 1'b1;
								end
								ST_INC: next_q.memoryAddressRegister =
									incAddr(q.memoryAddressRegister, 1'b0); // R20
								ST_INC_WREG2: next_q.memoryAddressRegister =
									incAddr(q.memoryAddressRegister, 1'b1); // R8 R20
								ST_MEM_RD: begin
									if (q.busState == IDLE) begin
										next_q.busState = WAIT_RD; // R22
										next_q.memReqRdN = 1'b0;
										next_q.memDone = 1'b0;
									end
								end
								ST_MEM_WR: begin
									if (q.busState == IDLE) begin
										next_q.busState = WAIT_WR;
										next_q.memReqWrN = 1'b0;
										next_q.memDone = 1'b0;
									end
								end
								default: next_q.pslverr = 1'b1;
							endcase
							if ((stepCode >= ST_LD_BUF) && (stepCode <= ST_LD_CHAN)) begin
								next_q.needClear = 1'b1;
							end
							if (stepCode == ST_CHAN_INC) begin
								next_q.needClear = 1'b1;
							end
						end
					end
					default: next_q.pslverr = 1'b1;
				endcase
			end else begin
				unique case (paddr)
					OFF_CTRL: next_q.prdata = {29'h0, q.bootstrapMode, q.inhibitReloc,
						q.interleave};
					OFF_RELOC: next_q.prdata = {24'h00_0000, q.relocationOffsetRegister};
					OFF_SWITCH: next_q.prdata = {14'h0000, q.consoleSwitch};
					OFF_ADDR: next_q.prdata = {14'h0000, q.memoryAddressRegister};
					OFF_CHAN: next_q.prdata = {29'h0, q.channel};
					OFF_STATUS: next_q.prdata = {26'h0, q.needClear, q.memDone,
						(q.busState != IDLE), q.addressMatch, q.lowAddress, !q.fastSelN};
					OFF_STEP: next_q.prdata = RESP_RST;
					default: next_q.pslverr = 1'b1;
				endcase
			end
		end

		// Interleave only reroutes bank select; the bus keeps the relocated bits 21-25.
		next_q.busAddrN = ~relocAddr[14:0]; // R1 R3
		next_q.bankSelTrueN = ~bankBits; // R4
		next_q.bankSelCompN = bankBits;
		next_q.fastSelN = !(lowDecode && !q.bootstrapMode); // R10
		next_q.lowAddress = lowDecode; // R10
		next_q.addressMatch = (q.memoryAddressRegister == q.consoleSwitch); // R11
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			q <= '{memoryAddressRegister: ADDR_RST, relocationOffsetRegister: RELOC_RST,
				consoleSwitch: ADDR_RST, channel: 3'h0, interleave: 1'b0, inhibitReloc: 1'b0,
				bootstrapMode: 1'b0, needClear: 1'b0, memAck1: 1'b0, memAck2: 1'b0,
				memRdy1: 1'b0, memRdy2: 1'b0, memDone: 1'b0, busState: IDLE,
				prdata: RESP_RST, pready: 1'b0, pslverr: 1'b0, busAddrN: 15'h7FFF,
				bankSelTrueN: 5'h1F, bankSelCompN: 5'h1F, fastSelN: 1'b1,
				memReqRdN: 1'b1, memReqWrN: 1'b1, lowAddress: 1'b0, addressMatch: 1'b0};
		end else begin
			q <= next_q;
		end
	end

	assign prdata = q.prdata;
	assign pready = q.pready;
	assign pslverr = q.pslverr;
	assign busAddrN = q.busAddrN;
	assign bankSelTrueN = q.bankSelTrueN;
	assign bankSelCompN = q.bankSelCompN;
	assign fastSelN = q.fastSelN;
	assign memReqRdN = q.memReqRdN;
	assign memReqWrN = q.memReqWrN;
	assign lowAddress = q.lowAddress;
	assign addressMatch = q.addressMatch;

	a_bus_low_direct: assert property (@(posedge mclk) disable iff (sys_rst) // R3
		busAddrN[9:0] == ~$past(q.memoryAddressRegister[9:0]))
		else $error("Direct bus bits do not follow address register.");
	// Registered outputs still show reset levels at the first edge after release.
	// Checks that compare them with the register therefore skip that edge.
	a_bank_both_forms: assert property (@(posedge mclk) disable iff (sys_rst) // R4
		!$past(sys_rst) |-> bankSelTrueN == ~bankSelCompN)
		else $error("Bank select forms are not complementary.");
	a_fast_gate_boot: assert property (@(posedge mclk) disable iff (sys_rst) // R10
		$past(q.bootstrapMode) |-> fastSelN)
		else $error("Fast select asserted in bootstrap mode.");
	a_low_decode_val: assert property (@(posedge mclk) disable iff (sys_rst) // R9
		!$past(sys_rst) |-> lowAddress == ($past(q.memoryAddressRegister) <= 18'h0_000F))
		else $error("Low address decode wrong.");
	a_switch_match: assert property (@(posedge mclk) disable iff (sys_rst) // R11
		!$past(sys_rst)
		|-> addressMatch == ($past(q.memoryAddressRegister) == $past(q.consoleSwitch)))
		else $error("Switch compare wrong.");
	a_trap_forty: assert property (@(posedge mclk) disable iff (sys_rst) // R12
		(apbAccess && pwrite && paddr == OFF_STEP && stepCode == ST_SET_TRAP && !q.needClear
		&& q.memoryAddressRegister == ADDR_RST) |=> q.memoryAddressRegister == 18'h0_0020)
		else $error("Trap address is not 40.");
	a_wrap_seventeen: assert property (@(posedge mclk) disable iff (sys_rst) // R8
		(apbAccess && pwrite && paddr == OFF_STEP && stepCode == ST_INC_WREG2
		&& q.memoryAddressRegister == 18'h0_000F) |=> q.memoryAddressRegister == ADDR_RST)
		else $error("Second register increment did not wrap.");
	a_load_needs_clear: assert property (@(posedge mclk) disable iff (sys_rst) // R6
		(apbAccess && pwrite && paddr == OFF_STEP && stepCode == ST_LD_PC && q.needClear)
		|=> $stable(q.memoryAddressRegister) && pslverr)
		else $error("Load accepted without clear.");
	a_write_waits_ack: assert property (@(posedge mclk) disable iff (sys_rst) // R23
		(q.busState == WAIT_WR && !q.memAck2) |=> !memReqWrN)
		else $error("Write request dropped before acknowledge.");
	a_inhibit_passes: assert property (@(posedge mclk) disable iff (sys_rst) // R25
		(!$past(sys_rst) && $past(q.inhibitReloc))
		|-> busAddrN[14:10] == ~$past(q.memoryAddressRegister[14:10]))
		else $error("Inhibited relocation changed the bus bits.");
	a_reloc_sum: assert property (@(posedge mclk) disable iff (sys_rst) // R2 R24
		(!$past(sys_rst) && !$past(q.inhibitReloc)
		&& ($past(q.memoryAddressRegister[17:4]) != 14'h0000))
		|-> busAddrN[14:10] == ~($past(q.memoryAddressRegister[14:10])
		+ $past(q.relocationOffsetRegister[4:0])))
		else $error("Relocated bus bits are not the sum.");
	a_fast_unreloc: assert property (@(posedge mclk) disable iff (sys_rst) // R9
		(!$past(sys_rst) && ($past(q.memoryAddressRegister[17:4]) == 14'h0000))
		|-> busAddrN == ~$past(q.memoryAddressRegister[14:0]))
		else $error("Fast memory address was relocated.");
	a_fast_sel_low: assert property (@(posedge mclk) disable iff (sys_rst) // R10
		!$past(q.bootstrapMode) |-> fastSelN == !lowAddress)
		else $error("Fast select does not follow the low decode.");
	a_interleave_bank: assert property (@(posedge mclk) disable iff (sys_rst) // R5
		(!$past(sys_rst) && $past(q.interleave))
		|-> bankSelCompN[4] == $past(q.memoryAddressRegister[BIT35]))
		else $error("Interleave did not put bit 35 in place of bit 21.");
	a_no_interleave: assert property (@(posedge mclk) disable iff (sys_rst) // R5
		(!$past(sys_rst) && !$past(q.interleave))
		|-> bankSelCompN == ~busAddrN[14:10])
		else $error("Bank select differs from bus bits 21-25.");
	a_clear_zero: assert property (@(posedge mclk) disable iff (sys_rst) // R6
		(apbAccess && pwrite && paddr == OFF_STEP && stepCode == ST_CLEAR)
		|=> q.memoryAddressRegister == ADDR_RST && !q.needClear)
		else $error("Clear pulse did not clear the address register.");
	a_pc_load: assert property (@(posedge mclk) disable iff (sys_rst) // R14
		(apbAccess && pwrite && paddr == OFF_STEP && stepCode == ST_LD_PC && !q.needClear)
		|=> q.memoryAddressRegister == $past(programCounter))
		else $error("Counter load wrong.");
	a_buf_load: assert property (@(posedge mclk) disable iff (sys_rst) // R15
		(apbAccess && pwrite && paddr == OFF_STEP && stepCode == ST_LD_BUF && !q.needClear)
		|=> q.memoryAddressRegister == $past(bufferWordRegister))
		else $error("Buffer load wrong.");
	a_switch_load: assert property (@(posedge mclk) disable iff (sys_rst) // R6
		(apbAccess && pwrite && paddr == OFF_STEP && stepCode == ST_LD_SW && !q.needClear)
		|=> q.memoryAddressRegister == $past(q.consoleSwitch))
		else $error("Switch load wrong.");
	a_chan_addr: assert property (@(posedge mclk) disable iff (sys_rst) // R13
		(apbAccess && pwrite && paddr == OFF_STEP && stepCode == ST_LD_CHAN && !q.needClear)
		|=> q.memoryAddressRegister[BIT30]
		&& q.memoryAddressRegister[3:1] == $past(q.channel))
		else $error("Channel address wrong.");
	a_chan_inc_bit: assert property (@(posedge mclk) disable iff (sys_rst) // R21
		(apbAccess && pwrite && paddr == OFF_STEP && stepCode == ST_CHAN_INC && !q.needClear)
		|=> q.memoryAddressRegister[BIT30] && q.memoryAddressRegister[BIT35]
		&& q.memoryAddressRegister[3:1] == $past(q.channel))
		else $error("Channel address with increment wrong.");
	a_inc_plain: assert property (@(posedge mclk) disable iff (sys_rst) // R20
		(apbAccess && pwrite && paddr == OFF_STEP && stepCode == ST_INC)
		|=> q.memoryAddressRegister == $past(q.memoryAddressRegister) + 18'h0_0001)
		else $error("Increment did not add one.");
	a_index_low: assert property (@(posedge mclk) disable iff (sys_rst) // R7
		(apbAccess && pwrite && paddr == OFF_STEP && stepCode == ST_LD_INDEX && !q.needClear)
		|=> q.memoryAddressRegister[3:0] == $past(instrIndexField)
		&& q.memoryAddressRegister[17:4] == $past(q.memoryAddressRegister[17:4]))
		else $error("Index load touched more than bits 32-35.");
	a_refuse_keeps: assert property (@(posedge mclk) disable iff (sys_rst) // R6
		(apbAccess && pwrite && paddr == OFF_STEP && q.needClear
		&& stepCode >= ST_LD_BUF && stepCode <= ST_LD_CHAN)
		|=> $stable(q.memoryAddressRegister) && pslverr)
		else $error("Load without clear changed the register.");
	a_read_waits_data: assert property (@(posedge mclk) disable iff (sys_rst) // R23
		(q.busState == WAIT_RD && !q.memRdy2) |=> !memReqRdN)
		else $error("Read request dropped before data.");
	a_req_one_kind: assert property (@(posedge mclk) disable iff (sys_rst) // R22
		memReqRdN || memReqWrN)
		else $error("Read and write requested together.");
	a_pready_pulse: assert property (@(posedge mclk) disable iff (sys_rst) // R26
		pready |=> !pready)
		else $error("Ready lasted more than one cycle.");
	a_pslverr_ready: assert property (@(posedge mclk) disable iff (sys_rst) // R6
		pslverr |-> pready)
		else $error("Error flagged without ready.");
endmodule
`default_nettype wire

// ---- verification/mas_mem_model.sv ----
// Behavioural memory bank that answers the sequencer's read and write requests.
`default_nettype none
module mas_mem_model (
	// Clock.
	input wire logic mclk,
	// Requests from the sequencer, active low.
	input wire logic memReqRdN,
	input wire logic memReqWrN,
	// Answer delay in cycles.
	input wire logic [3:0] waitCycles,
	// Answers to the sequencer.
	output logic memAckIn,
	output logic memDataReadyIn
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt;
	initial begin
		cnt = 0;
		memAckIn = 1'h0;
		memDataReadyIn = 1'h0;
	end
	// A read is acknowledged at once but its data comes late, so a sequencer
	// that releases a read on the acknowledge alone is caught.
	always @(posedge mclk) begin
		if (memReqRdN && memReqWrN) begin
			cnt <= 0;
			memAckIn <= 1'h0;
			memDataReadyIn <= 1'h0;
		end else begin
			cnt <= cnt + 1;
			memAckIn <= !memReqRdN || cnt >= waitCycles;
			memDataReadyIn <= !memReqRdN && cnt >= waitCycles;
		end
	end
endmodule
`default_nettype wire

// ---- verification/mas_sequencer_tb.sv ----
// Self-checking testbench for the memory address sequencer.
`default_nettype none
module mas_sequencer_tb;
	import mas_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk = 1'h0;
	logic sys_rst, psel, penable, pwrite, pready, pslverr, memAckIn, memDataReadyIn;
	logic fastSelN, memReqRdN, memReqWrN, lowAddress, addressMatch;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [17:0] bufferWordRegister, programCounter;
	logic [3:0] instrIndexField, instrAcField, waitCycles;
	logic [14:0] busAddrN;
	logic [4:0] bankSelTrueN, bankSelCompN;
	int nMismatch = 0;
	int checksDone = 0;
	always #5 mclk = ~mclk;
	mas_sequencer mas_sequencer_i (.mclk(mclk), .sys_rst(sys_rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .bufferWordRegister(bufferWordRegister),
		.programCounter(programCounter), .instrIndexField(instrIndexField),
		.instrAcField(instrAcField), .memAckIn(memAckIn), .memDataReadyIn(memDataReadyIn),
		.busAddrN(busAddrN), .bankSelTrueN(bankSelTrueN), .bankSelCompN(bankSelCompN),
		.fastSelN(fastSelN), .memReqRdN(memReqRdN), .memReqWrN(memReqWrN),
		.lowAddress(lowAddress), .addressMatch(addressMatch));
	mas_mem_model mas_mem_model_i (.mclk(mclk), .memReqRdN(memReqRdN), .memReqWrN(memReqWrN),
		.waitCycles(waitCycles), .memAckIn(memAckIn), .memDataReadyIn(memDataReadyIn));
	task automatic endOfTest();
		$display("checks %0d mismatches %0d", checksDone, nMismatch);
		if (nMismatch == 0 && checksDone > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checksDone++;
		if (got !== exp) begin
			nMismatch++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Called just after a rising edge; returns just after one.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
			output logic [31:0] r, output logic e);
		int n;
		logic ok;
		n = 0;
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'h1;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'h1 && n < 16);
		ok = (pready === 1'h1);
		r = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge mclk);
		if (!ok) begin
			nMismatch++;
			endOfTest();
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic expErr);
		logic [31:0] r;
		logic e;
		apb(1'h1, a, d, r, e);
		chk({31'h0, e}, {31'h0, expErr});
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] r);
		logic e;
		apb(1'h0, a, 32'h0000_0000, r, e);
	endtask
	task automatic step(input logic [4:0] code, input logic expErr);
		wr(OFF_STEP, {27'h0, code}, expErr);
	endtask
	// Optional clear, one step, then the address register is read back.
	task automatic seq(input logic clr, input logic [4:0] code, input logic [31:0] exp);
		logic [31:0] r;
		if (clr) step(ST_CLEAR, 1'h0);
		step(code, 1'h0);
		rd(OFF_ADDR, r);
		chk(r, exp);
	endtask
	task automatic chkPins(input logic [17:0] a, input logic [7:0] rl, input logic [2:0] ctl);
		logic [17:0] s;
		logic [4:0] bk;
		logic low;
		repeat (3) @(posedge mclk);
		low = (a[17:4] == 14'h0);
		s = (ctl[1] || low) ? a : a + {rl, 10'h000};
		bk = ctl[0] ? {a[0], s[13:10]} : s[14:10];
		chk({17'h0, busAddrN}, {17'h0, ~s[14:0]});
		chk({22'h0, bankSelTrueN, bankSelCompN}, {22'h0, ~bk, bk});
		chk({30'h0, lowAddress, fastSelN}, {30'h0, low, ~(low && !ctl[2])});
	endtask
	task automatic waitReq(input logic isRd, input logic lvl, output int n);
		n = 0;
		while ((isRd ? memReqRdN : memReqWrN) !== lvl && n < 40) begin
			@(posedge mclk);
			n++;
		end
		if (n >= 40) begin
			nMismatch++;
			endOfTest();
		end
	endtask
	task automatic sLoad();
		wr(OFF_RELOC, 32'h0000_006F, 1'h0);
		chkPins(18'h0_0000, 8'h6F, 3'h0);
		step(ST_CLEAR, 1'h0);
		step(ST_LD_PC, 1'h0);
		step(ST_LD_PC, 1'h1);
		step(ST_LD_BUF, 1'h1);
		seq(1'h0, ST_INC, 32'h0002_5404);
		chkPins(18'h2_5404, 8'h6F, 3'h0);
		wr(OFF_CTRL, 32'h0000_0001, 1'h0);
		chkPins(18'h2_5404, 8'h6F, 3'h1);
		wr(OFF_CTRL, 32'h0000_0002, 1'h0);
		chkPins(18'h2_5404, 8'h6F, 3'h2);
		wr(OFF_CTRL, 32'h0000_0000, 1'h0);
		seq(1'h1, ST_LD_BUF, 32'h0000_1234);
	endtask
	task automatic sShort();
		seq(1'h1, ST_SET_TRAP, 32'h0000_0020);
		seq(1'h0, ST_INC, 32'h0000_0021);
		wr(OFF_CHAN, 32'h0000_0005, 1'h0);
		seq(1'h1, ST_LD_CHAN, 32'h0000_002A);
		seq(1'h1, ST_CHAN_INC, 32'h0000_002B);
		seq(1'h1, ST_LD_INDEX, 32'h0000_000F);
		seq(1'h0, ST_INC_WREG2, 32'h0000_0000);
		seq(1'h1, ST_LD_WREG, 32'h0000_000F);
		wr(OFF_CTRL, 32'h0000_0004, 1'h0);
		chkPins(18'h0_000F, 8'h6F, 3'h4);
		wr(OFF_CTRL, 32'h0000_0000, 1'h0);
		seq(1'h0, ST_INC, 32'h0000_0010);
		chkPins(18'h0_0010, 8'h6F, 3'h0);
	endtask
	task automatic sMatch();
		wr(OFF_SWITCH, 32'h0001_2345, 1'h0);
		seq(1'h1, ST_LD_SW, 32'h0001_2345);
		chk({31'h0, addressMatch}, 32'h0000_0001);
		seq(1'h0, ST_INC, 32'h0001_2346);
		chk({31'h0, addressMatch}, 32'h0000_0000);
	endtask
	task automatic sMem(input logic isRd, input logic [3:0] dly);
		int n;
		logic [31:0] r;
		waitCycles <= dly;
		step(isRd ? ST_MEM_RD : ST_MEM_WR, 1'h0);
		waitReq(isRd, 1'h0, n);
		waitReq(isRd, 1'h1, n);
		chk({31'h0, n > int'(dly) && n < int'(dly) + 10}, 32'h0000_0001);
		rd(OFF_STATUS, r);
		chk(r & 32'h0000_0018, 32'h0000_0010);
	endtask
	task automatic sErr();
		logic [31:0] r;
		logic e;
		apb(1'h0, 12'h01C, 32'h0000_0000, r, e);
		chk({31'h0, e}, 32'h0000_0001);
		step(5'h1F, 1'h1);
	endtask
	initial begin
		{psel, penable, pwrite} = 3'h0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		bufferWordRegister = 18'h0_1234;
		programCounter = 18'h2_5403;
		instrIndexField = 4'hF;
		instrAcField = 4'hF;
		waitCycles = 4'h2;
		sys_rst = 1'h1;
		repeat (12) @(posedge mclk);
		chk({16'h0, busAddrN, lowAddress}, {16'h0, 15'h7FFF, 1'h0});
		sys_rst <= 1'h0;
		@(posedge mclk);
		sLoad();
		sShort();
		sMatch();
		sMem(1'h1, 4'h9);
		sMem(1'h0, 4'h5);
		sErr();
		endOfTest();
	end
	// Cuts a hang short well inside the cycle budget.
	initial begin
		#500000;
		nMismatch++;
		endOfTest();
	end
endmodule
`default_nettype wire
